// ---- design/frt_pkg.sv ----
package frt_pkg;

  // ----------------------------------------
  // counter values
  // ----------------------------------------
  localparam logic [15:0] FRT_COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] FRT_COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] FRT_COUNT_ONE = 16'h0001;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] FRT_OFF_MAIN_HIGH = 8'h00;
  localparam logic [7:0] FRT_OFF_MAIN_LOW = 8'h04;
  localparam logic [7:0] FRT_OFF_SHADOW_HIGH = 8'h08;
  localparam logic [7:0] FRT_OFF_SHADOW_LOW = 8'h0C;
  localparam logic [7:0] FRT_OFF_STATUS = 8'h10;
  localparam logic [7:0] FRT_OFF_CONTROL_ONE = 8'h14;
  localparam logic [7:0] FRT_OFF_CONTROL_TWO = 8'h18;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int FRT_STAT_OVF_BIT = 7;
  localparam int FRT_CTL1_OVIE_BIT = 5;
  localparam int FRT_CTL2_EDGE_BIT = 2;
  localparam int FRT_CTL2_PRESC_LSB = 0;
  localparam logic FRT_OVIE_RESET = 1'b0;
  localparam logic FRT_EDGE_RESET = 1'b0;
  localparam logic [1:0] FRT_PRESC_RESET = 2'h0;

  // ----------------------------------------
  // prescale_select encoding
  // ----------------------------------------
  localparam logic [1:0] FRT_PRESC_DIV4 = 2'h0;
  localparam logic [1:0] FRT_PRESC_DIV2 = 2'h1;
  localparam logic [1:0] FRT_PRESC_DIV8 = 2'h2;
  localparam logic [1:0] FRT_PRESC_EXT = 2'h3;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] frt_word(input logic [7:0] b);
    frt_word = {24'h000000, b};
  endfunction : frt_word

endpackage : frt_pkg

// ---- design/frt_tick_if.sv ----
// ----------------------------------------
// carrier between timer core and tick gen
// ----------------------------------------
interface frt_tick_if;
  logic [1:0] prescale_select;
  logic ext_edge_select;
  logic halt;
  logic tick;

  modport ctl (
    output prescale_select,
    output ext_edge_select,
    output halt,
    input tick
  );

  modport gen (
    input prescale_select,
    input ext_edge_select,
    input halt,
    output tick
  );
endinterface : frt_tick_if

// ---- design/frt_tick_gen.sv ----
module frt_tick_gen #(
  parameter bit PIN_BONDED = 1'b1 // 0: pin not bonded out
) (
  input wire logic core_clk_i, // cpu clock
  input wire logic nrst_i, // async reset, low
  input wire logic ext_pin_i, // external_timer_clock_pin
  frt_tick_if.gen tif // control and tick
);
  import frt_pkg::*;

  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic [2:0] div_reg;
  logic [2:0] div_next;

  // ----------------------------------------
  // external pin
  // ----------------------------------------
  wire ext_level = PIN_BONDED ? ext_pin_i : 1'b1;

  // first stage on the falling cpu edge so counting lines up with
  // it; costs half a cycle of settling time
  always_ff @(negedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_meta_reg <= 1'b1;
    end else begin
      ext_meta_reg <= ext_level;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_sync_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  wire ext_rise = ext_sync_reg & ~ext_prev_reg;
  wire ext_fall = ~ext_sync_reg & ext_prev_reg;
  wire ext_edge = tif.ext_edge_select ? ext_rise : ext_fall;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  assign div_next = tif.halt ? div_reg : div_reg + 3'h1;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  wire is_ext = tif.prescale_select == FRT_PRESC_EXT;
  wire div_hit =
    (tif.prescale_select == FRT_PRESC_DIV2) ? div_reg[0] :
    (tif.prescale_select == FRT_PRESC_DIV4) ? &div_reg[1:0] :
    &div_reg;

  // halt freezes both sources
  assign tif.tick = ~tif.halt & (is_ext ? ext_edge : div_hit);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_div2_gap;
    @(posedge core_clk_i) disable iff (!nrst_i)
    tif.tick && tif.prescale_select == FRT_PRESC_DIV2 |=>
      !tif.tick || tif.prescale_select != FRT_PRESC_DIV2;
  endproperty
  a_div2_gap: assert property (p_div2_gap)
    else $error("divide by two ticked twice in a row");

  property p_div8_gap;
    @(posedge core_clk_i) disable iff (!nrst_i)
    tif.tick && tif.prescale_select == FRT_PRESC_DIV8 |=>
      (!tif.tick || tif.prescale_select != FRT_PRESC_DIV8) [*7];
  endproperty
  a_div8_gap: assert property (p_div8_gap)
    else $error("divide by eight ticked early");

endmodule : frt_tick_gen

// ---- design/frt_timer_top.sv ----
// What this block does
// - 16-bit free running up-counter, read as high and low byte.
// - main and shadow count views always show the same value.
// - writing either low byte reloads the counter with FFFC.
// - counter starts at FFFC after reset; FFFC is its only load.
// - counter advances at cpu clock over 2, 4, 8 or external.
// - external clock used only when both select bits are one.
// - ext_edge_select picks rising or falling external edge.
// - external counting is synchronised to falling cpu edge.
// - high byte read first latches the matching low byte.
// - latched low byte holds until low byte is read.
// - after a finished sequence, low read gives live low byte.
// - wrap from FFFF to 0000 sets overflow_flag.
// - irq while flag, enable set and global mask clear.
// - status read with flag set, then main low access clears.
// - shadow low accesses never clear overflow_flag.
// - counter keeps running in wait mode.
// - halt stops the counter; reset restarts from FFFC.
// - a non-bonded timer input reads as constant one.
// - timer instances share nothing and each counts from its own inputs.
module frt_timer_top #(
  parameter bit PIN_BONDED = 1'b1 // 0: ext pin not bonded
) (
  input wire logic core_clk_i, // cpu clock, 20 MHz
  input wire logic nrst_i, // async reset, low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic ext_clk_pin_i, // external_timer_clock_pin
  input wire logic halt_i, // device in halt mode
  input wire logic global_mask_i, // cpu interrupt mask
  output logic irq_o // overflow interrupt request
);
  import frt_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] low_latch_reg;
  logic [7:0] low_latch_next;
  logic latched_reg;
  logic latched_next;
  logic overflow_flag_reg;
  logic overflow_flag_next;
  logic clear_armed_reg;
  logic clear_armed_next;
  logic overflow_irq_enable_reg;
  logic [1:0] prescale_select_reg;
  logic ext_edge_select_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ----------------------------------------
  // tick generator
  // ----------------------------------------
  frt_tick_if tif ();

  assign tif.prescale_select = prescale_select_reg;
  assign tif.ext_edge_select = ext_edge_select_reg;
  // wait mode has no input here: counter simply keeps going
  assign tif.halt = halt_i;

  frt_tick_gen #(
    .PIN_BONDED(PIN_BONDED)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ext_pin_i(ext_clk_pin_i),
    .tif(tif)
  );

  wire tick = tif.tick;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // reads act in the setup cycle so the sampled byte and the latched
  // low byte come from the same count value
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire rd_setup = setup & ~pwrite_i;
  wire wr_access = access & pwrite_i;

  wire hit_main_high = paddr_i == FRT_OFF_MAIN_HIGH;
  wire hit_main_low = paddr_i == FRT_OFF_MAIN_LOW;
  wire hit_shadow_high = paddr_i == FRT_OFF_SHADOW_HIGH;
  wire hit_shadow_low = paddr_i == FRT_OFF_SHADOW_LOW;
  wire hit_status = paddr_i == FRT_OFF_STATUS;
  wire hit_ctl1 = paddr_i == FRT_OFF_CONTROL_ONE;
  wire hit_ctl2 = paddr_i == FRT_OFF_CONTROL_TWO;
  wire hit_high = hit_main_high | hit_shadow_high;
  wire hit_low = hit_main_low | hit_shadow_low;
  wire mapped = hit_high | hit_low | hit_status | hit_ctl1 | hit_ctl2;

  wire rd_high = rd_setup & hit_high;
  wire rd_low = rd_setup & hit_low;
  wire wr_low = wr_access & hit_low;
  // only the main low view takes part in clearing the flag
  wire main_low_touch = (rd_setup | wr_access) & hit_main_low;

  // no wait states; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign prdata_o = prdata_reg;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // a reload in the same cycle wins, so no rollover happens then
  wire wrap = tick & ~wr_low & (count_reg == FRT_COUNT_TOP);

  always_comb begin
    count_next = count_reg;
    if (wr_low) begin
      count_next = FRT_COUNT_RESET;
    end else if (tick) begin
      count_next = count_reg + FRT_COUNT_ONE;
    end
  end

  // ----------------------------------------
  // 16-bit read sequence
  // ----------------------------------------
  always_comb begin
    low_latch_next = low_latch_reg;
    latched_next = latched_reg;
    if (rd_high && !latched_reg) begin
      low_latch_next = count_reg[7:0];
      latched_next = 1'b1;
    end else if (rd_low) begin
      latched_next = 1'b0;
    end
  end

  // repeated high reads leave the latch alone
  wire [7:0] low_view = latched_reg ? low_latch_reg :
    count_reg[7:0];

  // ----------------------------------------
  // overflow flag
  // ----------------------------------------
  wire overflow_clear = main_low_touch & clear_armed_reg;

  always_comb begin
    // a wrap in the clearing cycle keeps the flag set
    overflow_flag_next = wrap |
      (overflow_flag_reg & ~overflow_clear);
    clear_armed_next = clear_armed_reg;
    if (overflow_clear) begin
      clear_armed_next = 1'b0;
    end else if (rd_setup && hit_status && overflow_flag_reg) begin
      clear_armed_next = 1'b1;
    end
  end

  // pending flag raises the request once enable and mask allow it
  assign irq_o = overflow_flag_reg & overflow_irq_enable_reg &
    ~global_mask_i;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  wire [7:0] status_byte =
    8'(overflow_flag_reg) << FRT_STAT_OVF_BIT;
  wire [7:0] ctl1_byte =
    8'(overflow_irq_enable_reg) << FRT_CTL1_OVIE_BIT;
  wire [7:0] ctl2_byte =
    (8'(ext_edge_select_reg) << FRT_CTL2_EDGE_BIT) |
    (8'(prescale_select_reg) << FRT_CTL2_PRESC_LSB);

  wire [7:0] rd_byte =
    hit_high ? count_reg[15:8] :
    hit_low ? low_view :
    hit_status ? status_byte :
    hit_ctl1 ? ctl1_byte :
    hit_ctl2 ? ctl2_byte : 8'h00;

  assign prdata_next = rd_setup ? frt_word(rd_byte) : prdata_reg;

  // ----------------------------------------
  // flip-flops
  // ----------------------------------------
  // every instance holds all of its own state
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= FRT_COUNT_RESET;
      low_latch_reg <= 8'h00;
      latched_reg <= 1'b0;
      overflow_flag_reg <= 1'b0;
      clear_armed_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      count_reg <= count_next;
      low_latch_reg <= low_latch_next;
      latched_reg <= latched_next;
      overflow_flag_reg <= overflow_flag_next;
      clear_armed_reg <= clear_armed_next;
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow_irq_enable_reg <= FRT_OVIE_RESET;
      prescale_select_reg <= FRT_PRESC_RESET;
      ext_edge_select_reg <= FRT_EDGE_RESET;
    end else if (wr_access && hit_ctl1) begin
      overflow_irq_enable_reg <= pwdata_i[FRT_CTL1_OVIE_BIT];
    end else if (wr_access && hit_ctl2) begin
      prescale_select_reg <= pwdata_i[FRT_CTL2_PRESC_LSB +: 2];
      ext_edge_select_reg <= pwdata_i[FRT_CTL2_EDGE_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_reload;
    wr_low |=> count_reg == FRT_COUNT_RESET;
  endproperty
  a_reload: assert property (p_reload)
    else $error("low byte write did not reload the counter");

  property p_only_load;
    count_reg != $past(count_reg) |->
      count_reg == $past(count_reg) + FRT_COUNT_ONE ||
      count_reg == FRT_COUNT_RESET;
  endproperty
  a_only_load: assert property (p_only_load)
    else $error("counter took a value other than step or reload");

  property p_advance;
    tick && !wr_low |=> count_reg == $past(count_reg) + FRT_COUNT_ONE;
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter missed a tick");

  property p_high_view;
    rd_high |=> prdata_o[15:0] == {8'h00, $past(count_reg[15:8])};
  endproperty
  a_high_view: assert property (p_high_view)
    else $error("high view differs from count");

  property p_latch_pair;
    rd_low && latched_reg |=> prdata_o[7:0] == $past(low_latch_reg);
  endproperty
  a_latch_pair: assert property (p_latch_pair)
    else $error("low byte not taken from latch");

  property p_latch_hold;
    latched_reg && !rd_low |=> latched_reg && $stable(low_latch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched low byte changed early");

  property p_live_low;
    rd_low && !latched_reg |=> prdata_o[7:0] == $past(count_reg[7:0]);
  endproperty
  a_live_low: assert property (p_live_low)
    else $error("single low read not live");

  property p_wrap_sets;
    wrap |=> overflow_flag_reg && count_reg == 16'h0000;
  endproperty
  a_wrap_sets: assert property (p_wrap_sets)
    else $error("wrap did not set overflow flag");

  property p_wrap_only;
    $rose(overflow_flag_reg) |->
      $past(count_reg) == FRT_COUNT_TOP && count_reg == 16'h0000;
  endproperty
  a_wrap_only: assert property (p_wrap_only)
    else $error("overflow flag set without a rollover");

  property p_irq_gate;
    irq_o == (overflow_flag_reg && overflow_irq_enable_reg &&
      !global_mask_i);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without pending unmasked flag");

  property p_clear;
    clear_armed_reg && main_low_touch && !wrap |=> !overflow_flag_reg;
  endproperty
  a_clear: assert property (p_clear)
    else $error("two step sequence did not clear flag");

  property p_arm;
    rd_setup && hit_status && overflow_flag_reg |=> clear_armed_reg;
  endproperty
  a_arm: assert property (p_arm)
    else $error("status read with flag set did not arm the clear");

  property p_unarmed_keeps;
    overflow_flag_reg && !clear_armed_reg |=> overflow_flag_reg;
  endproperty
  a_unarmed_keeps: assert property (p_unarmed_keeps)
    else $error("overflow flag cleared without a status read first");

  property p_shadow_keeps;
    overflow_flag_reg && !main_low_touch |=> overflow_flag_reg;
  endproperty
  a_shadow_keeps: assert property (p_shadow_keeps)
    else $error("overflow flag lost without main low access");

  property p_halt_hold;
    halt_i && !wr_low |=> $stable(count_reg);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("counter moved in halt");

  property p_ctl_hold;
    !(wr_access && (hit_ctl1 || hit_ctl2)) |=>
      $stable(overflow_irq_enable_reg) && $stable(ext_edge_select_reg) &&
      $stable(prescale_select_reg);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("control bits changed without a write");

  property p_read_zero;
    rd_setup |=> prdata_o[31:8] == 24'h000000;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("read data above the byte not zero");

  c_wrap: cover property (wrap);
  c_clear: cover property (overflow_clear && overflow_flag_reg);
  c_pair: cover property (rd_high ##[1:20] rd_low);
  c_ext: cover property (prescale_select_reg == FRT_PRESC_EXT && tick);

endmodule : frt_timer_top

// ---- testbench/tb_frt_timer_top.sv ----
module tb_frt_timer_top;
  timeunit 1ns;
  timeprecision 100ps;
  import frt_pkg::*;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] prdata_nb;
  logic pready;
  logic pslverr;
  logic ext_pin;
  logic halt;
  logic gmask;
  logic irq;
  logic [31:0] rd;
  logic [31:0] rd_nb;
  logic err;
  logic [15:0] v;
  logic [15:0] w;
  int error_cnt = 0;
  int compares = 0;
  int dv[4] = '{4, 2, 8, 8};

  always #25 clk = ~clk;

  frt_timer_top uut (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_clk_pin_i(ext_pin), .halt_i(halt), .global_mask_i(gmask),
    .irq_o(irq)
  );

  // second copy with the pin not bonded, fed the same traffic
  frt_timer_top #(.PIN_BONDED(1'b0)) uut_nb (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_nb), .pready_o(), .pslverr_o(),
    .ext_clk_pin_i(ext_pin), .halt_i(halt), .global_mask_i(gmask),
    .irq_o()
  );

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; one idle cycle after each transfer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    rd_nb = prdata_nb;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic get16(input logic [7:0] hi, output logic [15:0] val);
    apb(1'b0, hi, 32'h0);
    val[15:8] = rd[7:0];
    apb(1'b0, hi + 8'h04, 32'h0);
    val[7:0] = rd[7:0];
  endtask : get16

  // counts advanced since reload, within tol of e
  task automatic near(input logic [15:0] val, input int e, input int tol);
    logic [15:0] d;
    logic ok;
    d = val - FRT_COUNT_RESET;
    ok = ($signed(d) >= e - tol) && ($signed(d) <= e + tol);
    chk({31'h0, ok}, 32'h1);
  endtask : near

  // n unhalted cycles, pin toggling every 4 (one rising edge per 8)
  task automatic run(input int n);
    halt <= 1'b0;
    for (int i = 0; i < n / 4; i++) begin
      repeat (4) @(posedge clk);
      ext_pin <= ~ext_pin;
    end
    halt <= 1'b1;
    @(posedge clk);
  endtask : run

  task automatic pin_step(input logic lvl);
    halt <= 1'b0;
    ext_pin <= lvl;
    repeat (8) @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
  endtask : pin_step

  // irq is combinational: look mid-cycle, after the edge has settled
  task automatic irq_chk(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge clk);
  endtask : irq_chk

  task automatic print_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // watchdog, far beyond the few hundred cycles needed
  // ----------------------------------------
  initial begin
    #(50 * 20000);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_pin = 1'b0;
    halt = 1'b1;
    gmask = 1'b1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // held in halt from reset, so the count is still the start value
    rdc(FRT_OFF_STATUS, 32'h0);
    rdc(FRT_OFF_CONTROL_ONE, 32'h0);
    rdc(FRT_OFF_CONTROL_TWO, 32'h0);
    get16(FRT_OFF_MAIN_HIGH, v);
    chk({16'h0, v}, {16'h0, FRT_COUNT_RESET});
    get16(FRT_OFF_SHADOW_HIGH, v);
    chk({16'h0, v}, {16'h0, FRT_COUNT_RESET});
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h1C, 32'h0000_0055);
    chk({31'h0, err}, 32'h1);
    // every prescale code, pin toggling in all of them
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, FRT_OFF_CONTROL_TWO, m);
      apb(1'b1, FRT_OFF_SHADOW_LOW, 32'h0);
      run(64);
      get16(FRT_OFF_MAIN_HIGH, v);
      near(v, 64 / dv[m], 1);
      if (m == 3) begin
        chk(rd_nb, 32'h0000_00FC);
      end else begin
        chk(rd_nb, rd);
      end
      get16(FRT_OFF_SHADOW_HIGH, w);
      chk({16'h0, w}, {16'h0, v});
    end
    // one pin edge at a time, both edge selections
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, FRT_OFF_CONTROL_TWO, 32'h3 | (e << FRT_CTL2_EDGE_BIT));
      apb(1'b1, FRT_OFF_MAIN_LOW, 32'h0);
      pin_step(1'b1);
      get16(FRT_OFF_MAIN_HIGH, v);
      chk({16'h0, v}, 32'h0000_FFFC + e);
      pin_step(1'b0);
      get16(FRT_OFF_MAIN_HIGH, v);
      chk({16'h0, v}, 32'h0000_FFFD);
    end
    // latched low byte survives running and a repeated high read
    apb(1'b1, FRT_OFF_CONTROL_TWO, {30'h0, FRT_PRESC_DIV2});
    apb(1'b1, FRT_OFF_SHADOW_LOW, 32'h0);
    rdc(FRT_OFF_MAIN_HIGH, 32'h0000_00FF);
    run(64);
    rdc(FRT_OFF_MAIN_HIGH, 32'h0000_0000);
    rdc(FRT_OFF_MAIN_LOW, 32'h0000_00FC);
    get16(FRT_OFF_SHADOW_HIGH, v);
    near(v, 32, 1);
    apb(1'b0, FRT_OFF_MAIN_LOW, 32'h0);
    chk(rd, {24'h0, v[7:0]});
    // overflow: start clean, wrap, then the two-step clear
    // main low reads above came before any status read with the flag set: flag still set
    rdc(FRT_OFF_STATUS, 32'h0000_0080);
    apb(1'b1, FRT_OFF_MAIN_LOW, 32'h0);
    rdc(FRT_OFF_STATUS, 32'h0);
    run(16);
    rdc(FRT_OFF_STATUS, 32'h0000_0080);
    irq_chk(1'b0);
    apb(1'b1, FRT_OFF_CONTROL_ONE, 32'h0000_0020);
    irq_chk(1'b0);
    gmask <= 1'b0;
    irq_chk(1'b1);
    apb(1'b0, FRT_OFF_SHADOW_LOW, 32'h0);
    rdc(FRT_OFF_STATUS, 32'h0000_0080);
    apb(1'b1, FRT_OFF_SHADOW_LOW, 32'h0);
    rdc(FRT_OFF_STATUS, 32'h0000_0080);
    apb(1'b0, FRT_OFF_MAIN_LOW, 32'h0);
    rdc(FRT_OFF_STATUS, 32'h0);
    irq_chk(1'b0);
    // mid-run reset: count moved and flag set, both must return
    run(8);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    get16(FRT_OFF_MAIN_HIGH, v);
    chk({16'h0, v}, {16'h0, FRT_COUNT_RESET});
    rdc(FRT_OFF_STATUS, 32'h0);
    irq_chk(1'b0);
    print_verdict();
  end

endmodule : tb_frt_timer_top
